/* shared/ermw_defs.svh */
/*
 * Constants of the receive MAC with wake-up filters and receive DMA.
 * Assumes inclusion by bare name from files that need offsets, bit positions and counts.
 */
`ifndef ERMW_DEFS_SVH
`define ERMW_DEFS_SVH
`define ERMW_WAKE_FILTERS 4
`define ERMW_WAKE_WINDOW 31
`define ERMW_CRC_POLY 16'h8005
`define ERMW_CRC_SEED 16'hffff
`define ERMW_CMD_ON_BIT 0
`define ERMW_CMD_MCAST_BIT 3
`define ERMW_DES0_OWN_BIT 31
`define ERMW_DES0_LEN_LSB 16
`define ERMW_DES1_SUPPRESS_BIT 31
`define ERMW_DES1_CHAIN_BIT 14
`define ERMW_DES1_SIZE1_LSB 0
`define ERMW_DES1_SIZE2_LSB 16
`define ERMW_DESC_BYTES 32'h00000010
`define ERMW_WD_UNIT_CYCLES 256
`define ERMW_WD_PRESCALE_LAST 8'hff
`define ERMW_FIFO_DEPTH 16
`define ERMW_FIFO_WIDTH 9
`endif

/* shared/ermw_pkg.sv */
/*
 * Types shared by the receive MAC, its wake-up filter and its FIFO.
 * Assumes ermw_defs.svh for numeric constants.
 */
package ermw_pkg;
   typedef struct packed {
      logic [30:0] wake_byte_mask;
      logic [7:0] wake_filter_command;
      logic [7:0] wake_start_offset;
      logic [15:0] wake_expected_crc;
   } ermw_wake_cfg_type;

   typedef struct packed {
      logic last;
      logic [7:0] data;
   } ermw_byte_type;

   typedef enum logic [2:0] {
      DMA_IDLE = 3'b000,
      DMA_FETCH = 3'b001,
      DMA_FETCH_WAIT = 3'b010,
      DMA_CHECK = 3'b011,
      DMA_SUSPEND = 3'b100,
      DMA_WAIT_DATA = 3'b101,
      DMA_WRITE = 3'b110,
      DMA_CLOSE = 3'b111
   } ermw_dma_state_type;

   typedef struct packed {
      logic [15:0] crc;
      logic match;
   } ermw_filt_state_type;

   typedef struct packed {
      ermw_dma_state_type state;
      logic [1:0] fetch_idx;
      logic [31:0] cur_desc;
      logic [3:0][31:0] des;
      logic [13:0] byte_cnt;
      ermw_byte_type rx_byte;
      logic [31:0] list_base;
      logic [31:0] buf_addr;
      logic mem_we;
      logic mem_byte;
      logic [31:0] mem_addr;
      logic [31:0] mem_wdata;
      logic srst_busy;
      logic pd_woken;
      logic wake_status;
      logic rx_irq;
      logic wd_armed;
      logic [7:0] wd_pre;
      logic [7:0] wd_units;
      logic in_frame;
      logic frame_keep;
      logic frame_mcast;
      logic [15:0] frame_idx;
   } ermw_top_state_type;
endpackage

/* rtl/ermw_fifo.sv */
/*
 * Synchronous FIFO with valid and ready on both sides and a flush input.
 * Assumes one clock and an active-low asynchronous reset.
 */
`include "ermw_defs.svh"
module ermw_fifo import ermw_pkg::*; #(
   parameter int WIDTH = `ERMW_FIFO_WIDTH,
   parameter int DEPTH = `ERMW_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
   } ermw_fifo_state_type;

   ermw_fifo_state_type s_q, s_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   assign in_ready = (s_q.count != (AW+1)'(DEPTH));
   assign out_valid = (s_q.count != '0);
   assign out_data = mem[s_q.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      s_d = s_q;
      if (push)
      begin
         s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
      end
      if (pop)
      begin
         s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
      end
      s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
      if (flush)
      begin
         s_d = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[s_q.wr] <= in_data;
      end
   end
endmodule

/* rtl/ermw_wake_filter.sv */
/*
 * One remote wake-up filter: masked CRC16 over a byte window of a frame.
 * Assumes a byte stream with a frame-relative index and a last-byte marker.
 */
`include "ermw_defs.svh"
module ermw_wake_filter import ermw_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clr,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic byte_last,
   input wire logic [15:0] byte_index,
   input wire logic frame_mcast,
   input wire ermw_wake_cfg_type cfg,
   output logic match
);
   ermw_filt_state_type s_q, s_d;
   logic [15:0] rel;
   logic in_win;
   logic [15:0] crc_base, crc_now;
   logic type_ok;

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      logic fb;
      r = c;
      for (int i = 0; i < 8; i++)
      begin
         fb = r[15] ^ d[i];
         r = {r[14:0], 1'b0} ^ (fb ? `ERMW_CRC_POLY : 16'h0000);
      end
      return r;
   endfunction

   assign rel = byte_index - {8'h00, cfg.wake_start_offset};
   assign in_win = (byte_index >= {8'h00, cfg.wake_start_offset}) && (rel < 16'(`ERMW_WAKE_WINDOW));
   assign crc_base = (byte_index == 16'h0000) ? `ERMW_CRC_SEED : s_q.crc;
   assign crc_now = (in_win && cfg.wake_byte_mask[rel[4:0]]) ? crc_byte(crc_base, byte_data) : crc_base;
   assign type_ok = cfg.wake_filter_command[`ERMW_CMD_MCAST_BIT] == frame_mcast;
   assign match = s_q.match;

   always_comb
   begin
      s_d = s_q;
      s_d.match = 1'b0;
      if (byte_valid)
      begin
         s_d.crc = crc_now;
         if (byte_last)
         begin
            s_d.match = cfg.wake_filter_command[`ERMW_CMD_ON_BIT] && type_ok &&
                        (crc_now == cfg.wake_expected_crc);
         end
      end
      if (clr)
      begin
         s_d = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
endmodule

/* rtl/ermw_rx_mac.sv */
/*
 * Receive side of an Ethernet MAC: power-down wake-up filtering, soft reset,
 * receive FIFO, descriptor-driven receive DMA and the receive interrupt watchdog.
 * Assumes a byte stream from the line side, a simple memory port with a grant
 * for every request and read data returned later with a valid strobe.
 */
`include "ermw_defs.svh"
module ermw_rx_mac import ermw_pkg::*; #(
   parameter int FIFO_DEPTH = `ERMW_FIFO_DEPTH
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic RX_VALID,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_LAST,
   input wire logic RX_MCAST,
   output logic RX_READY,
   input wire logic RX_ENABLE,
   input wire logic POWER_DOWN_REQ,
   output logic POWER_DOWN_ACTIVE,
   input wire ermw_wake_cfg_type [`ERMW_WAKE_FILTERS-1:0] WAKE_CFG,
   input wire logic WAKE_STATUS_READ,
   output logic WAKE_STATUS,
   output logic POWER_MGMT_IRQ,
   input wire logic SOFT_RESET_REQ,
   input wire logic PHY_CLK_ALIVE,
   output logic SOFT_RESET_BUSY,
   input wire logic [31:0] DESC_LIST_BASE,
   input wire logic DESC_LIST_LOAD,
   output logic [31:0] DESC_LIST_BASE_RD,
   input wire logic [4:0] DESC_SKIP_WORDS,
   input wire logic RX_POLL_DEMAND,
   output logic [31:0] CUR_BUF_ADDR,
   output logic [31:0] CUR_DESC_ADDR,
   output logic RX_SUSPENDED,
   input wire logic [7:0] RX_WATCHDOG_TIMEOUT,
   output logic RX_IRQ,
   output logic MEM_REQ,
   output logic MEM_WE,
   output logic MEM_BYTE,
   output logic [31:0] MEM_ADDR,
   output logic [31:0] MEM_WDATA,
   input wire logic MEM_GNT,
   input wire logic MEM_RVALID,
   input wire logic [31:0] MEM_RDATA
);
   localparam int NF = `ERMW_WAKE_FILTERS;
   localparam ermw_top_state_type RESET_STATE = '0;

   ermw_top_state_type s_q, s_d;
   logic pd_active, cur_keep, in_take, fifo_in_ready, fifo_in_valid;
   logic fifo_out_valid, fifo_out_ready;
   ermw_byte_type fifo_out;
   logic [15:0] cur_idx;
   logic cur_mcast;
   logic [NF-1:0] match;
   logic [12:0] size1, size2;
   logic chained, suppress;

   assign pd_active = POWER_DOWN_REQ && !s_q.pd_woken;
   assign cur_keep = s_q.in_frame ? s_q.frame_keep : (RX_ENABLE && !pd_active);
   assign RX_READY = !s_q.srst_busy && (!cur_keep || fifo_in_ready);
   assign in_take = RX_VALID && RX_READY;
   assign fifo_in_valid = RX_VALID && cur_keep && !s_q.srst_busy;
   assign cur_idx = s_q.in_frame ? s_q.frame_idx : 16'h0000;
   assign cur_mcast = s_q.in_frame ? s_q.frame_mcast : RX_MCAST;
   assign size1 = s_q.des[1][`ERMW_DES1_SIZE1_LSB +: 13];
   assign size2 = s_q.des[1][`ERMW_DES1_SIZE2_LSB +: 13];
   assign chained = s_q.des[1][`ERMW_DES1_CHAIN_BIT];
   assign suppress = s_q.des[1][`ERMW_DES1_SUPPRESS_BIT];

   ermw_fifo #(
      .WIDTH(`ERMW_FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(CLOCK),
      .rst_n(RST_N),
      .flush(s_q.srst_busy),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data({RX_LAST, RX_DATA}),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out)
   );

   genvar g;
   generate
      for (g = 0; g < NF; g++)
      begin : gen_filt
         ermw_wake_filter u_filt (
            .clk(CLOCK),
            .rst_n(RST_N),
            .clr(s_q.srst_busy),
            .byte_valid(in_take && pd_active),
            .byte_data(RX_DATA),
            .byte_last(RX_LAST),
            .byte_index(cur_idx),
            .frame_mcast(cur_mcast),
            .cfg(WAKE_CFG[g]),
            .match(match[g])
         );
      end
   endgenerate

   assign fifo_out_ready = (s_q.state == DMA_WAIT_DATA);
   assign MEM_REQ = (s_q.state == DMA_FETCH) || (s_q.state == DMA_WRITE) || (s_q.state == DMA_CLOSE);
   assign MEM_WE = s_q.mem_we;
   assign MEM_BYTE = s_q.mem_byte;
   assign MEM_ADDR = s_q.mem_addr;
   assign MEM_WDATA = s_q.mem_wdata;
   assign POWER_DOWN_ACTIVE = pd_active;
   assign WAKE_STATUS = s_q.wake_status;
   assign POWER_MGMT_IRQ = s_q.wake_status;
   assign SOFT_RESET_BUSY = s_q.srst_busy;
   assign DESC_LIST_BASE_RD = s_q.list_base;
   assign CUR_BUF_ADDR = s_q.buf_addr;
   assign CUR_DESC_ADDR = s_q.cur_desc;
   assign RX_SUSPENDED = (s_q.state == DMA_SUSPEND);
   assign RX_IRQ = s_q.rx_irq;

   always_comb
   begin
      s_d = s_q;
      s_d.rx_irq = 1'b0;
      // Frame tracking on the line side.
      if (in_take)
      begin
         if (!s_q.in_frame)
         begin
            s_d.frame_keep = RX_ENABLE && !pd_active;
            s_d.frame_mcast = RX_MCAST;
         end
         s_d.in_frame = !RX_LAST;
         s_d.frame_idx = RX_LAST ? 16'h0000 : ((cur_idx == 16'hffff) ? cur_idx : cur_idx + 16'h0001);
      end
      // Power-down wake-up; a new wake event wins over a status read.
      if (!POWER_DOWN_REQ)
      begin
         s_d.pd_woken = 1'b0;
      end
      if (WAKE_STATUS_READ)
      begin
         s_d.wake_status = 1'b0;
      end
      if (pd_active && (match != '0))
      begin
         s_d.pd_woken = 1'b1;
         s_d.wake_status = 1'b1;
      end
      // Descriptor list base.
      if (DESC_LIST_LOAD)
      begin
         s_d.list_base = DESC_LIST_BASE;
      end
      // Receive interrupt watchdog.
      if (s_q.wd_armed && (RX_WATCHDOG_TIMEOUT != 8'h00))
      begin
         s_d.wd_pre = s_q.wd_pre + 8'h01;
         if (s_q.wd_pre == `ERMW_WD_PRESCALE_LAST)
         begin
            s_d.wd_units = s_q.wd_units + 8'h01;
            if ((s_q.wd_units + 8'h01) >= RX_WATCHDOG_TIMEOUT)
            begin
               s_d.rx_irq = 1'b1;
               s_d.wd_armed = 1'b0;
               s_d.wd_units = 8'h00;
            end
         end
      end
      // Receive DMA.
      case (s_q.state)
         DMA_IDLE:
         begin
            if (DESC_LIST_LOAD)
            begin
               s_d.cur_desc = DESC_LIST_BASE;
               s_d.fetch_idx = 2'd0;
               s_d.mem_we = 1'b0;
               s_d.mem_byte = 1'b0;
               s_d.mem_addr = DESC_LIST_BASE;
               s_d.state = DMA_FETCH;
            end
         end
         DMA_FETCH:
         begin
            if (MEM_GNT)
            begin
               s_d.state = DMA_FETCH_WAIT;
            end
         end
         DMA_FETCH_WAIT:
         begin
            if (MEM_RVALID)
            begin
               s_d.des[s_q.fetch_idx] = MEM_RDATA;
               s_d.fetch_idx = s_q.fetch_idx + 2'd1;
               s_d.mem_addr = s_q.mem_addr + 32'h00000004;
               s_d.state = (s_q.fetch_idx == 2'd3) ? DMA_CHECK : DMA_FETCH;
            end
         end
         DMA_CHECK:
         begin
            s_d.byte_cnt = 14'h0000;
            s_d.buf_addr = s_q.des[2];
            s_d.state = s_q.des[0][`ERMW_DES0_OWN_BIT] ? DMA_WAIT_DATA : DMA_SUSPEND;
         end
         DMA_SUSPEND:
         begin
            if (RX_POLL_DEMAND)
            begin
               s_d.fetch_idx = 2'd0;
               s_d.mem_addr = s_q.cur_desc;
               s_d.state = DMA_FETCH;
            end
         end
         DMA_WAIT_DATA:
         begin
            if (fifo_out_valid)
            begin
               s_d.rx_byte = fifo_out;
               s_d.byte_cnt = (s_q.byte_cnt == 14'h3fff) ? s_q.byte_cnt : s_q.byte_cnt + 14'h0001;
               s_d.mem_we = 1'b1;
               s_d.mem_byte = 1'b1;
               s_d.mem_wdata = {24'h000000, fifo_out.data};
               if ({1'b0, s_q.byte_cnt} < {2'b00, size1})
               begin
                  s_d.buf_addr = s_q.des[2] + {18'h00000, s_q.byte_cnt};
                  s_d.mem_addr = s_d.buf_addr;
                  s_d.state = DMA_WRITE;
               end
               else if (!chained && ({1'b0, s_q.byte_cnt} < ({2'b00, size1} + {2'b00, size2})))
               begin
                  s_d.buf_addr = s_q.des[3] + {18'h00000, s_q.byte_cnt} - {19'h00000, size1};
                  s_d.mem_addr = s_d.buf_addr;
                  s_d.state = DMA_WRITE;
               end
               else if (fifo_out.last)
               begin
                  s_d.state = DMA_CLOSE;
               end
               if (fifo_out.last && (s_d.state == DMA_CLOSE))
               begin
                  s_d.mem_byte = 1'b0;
                  s_d.mem_addr = s_q.cur_desc;
                  s_d.mem_wdata = 32'(s_d.byte_cnt) << `ERMW_DES0_LEN_LSB;
               end
            end
         end
         DMA_WRITE:
         begin
            if (MEM_GNT)
            begin
               s_d.state = s_q.rx_byte.last ? DMA_CLOSE : DMA_WAIT_DATA;
               s_d.mem_byte = 1'b0;
               s_d.mem_addr = s_q.cur_desc;
               s_d.mem_wdata = 32'(s_q.byte_cnt) << `ERMW_DES0_LEN_LSB;
            end
         end
         DMA_CLOSE:
         begin
            if (MEM_GNT)
            begin
               if (suppress)
               begin
                  s_d.wd_armed = 1'b1;
               end
               else
               begin
                  s_d.rx_irq = 1'b1;
                  s_d.wd_armed = 1'b0;
                  s_d.wd_pre = 8'h00;
                  s_d.wd_units = 8'h00;
               end
               s_d.cur_desc = chained ? s_q.des[3] :
                              s_q.cur_desc + `ERMW_DESC_BYTES + {25'h0000000, DESC_SKIP_WORDS, 2'b00};
               s_d.mem_addr = s_d.cur_desc;
               s_d.mem_we = 1'b0;
               s_d.fetch_idx = 2'd0;
               s_d.state = DMA_FETCH;
            end
         end
         default:
         begin
            s_d.state = DMA_IDLE;
         end
      endcase
      // Soft reset holds everything at defaults until the PHY clock is seen.
      if (SOFT_RESET_REQ)
      begin
         s_d.srst_busy = 1'b1;
      end
      if (s_q.srst_busy)
      begin
         s_d = RESET_STATE;
         s_d.srst_busy = !PHY_CLK_ALIVE;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         s_q <= RESET_STATE;
      end
      else
      begin
         s_q <= s_d;
      end
   end
endmodule

/* tb/ermw_rx_chk.sv */
/*
 * Concurrent checks on the ports of the receive MAC top module.
 * Assumes a bind from the bench top file, one clock and an active-low asynchronous reset.
 */
module ermw_rx_chk (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic RX_READY,
   input wire logic SOFT_RESET_REQ,
   input wire logic PHY_CLK_ALIVE,
   input wire logic SOFT_RESET_BUSY,
   input wire logic [31:0] DESC_LIST_BASE,
   input wire logic DESC_LIST_LOAD,
   input wire logic [31:0] DESC_LIST_BASE_RD,
   input wire logic RX_POLL_DEMAND,
   input wire logic [31:0] CUR_DESC_ADDR,
   input wire logic RX_SUSPENDED,
   input wire logic RX_IRQ,
   input wire logic WAKE_STATUS_READ,
   input wire logic WAKE_STATUS,
   input wire logic POWER_DOWN_ACTIVE,
   input wire logic POWER_MGMT_IRQ,
   input wire logic MEM_REQ,
   input wire logic MEM_WE,
   input wire logic [31:0] MEM_ADDR
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   // The refetch is a read request at the descriptor that stalled the engine.
   sequence s_refetch;
      ##[1:3] (MEM_REQ && !MEM_WE && MEM_ADDR == CUR_DESC_ADDR);
   endsequence
   sequence s_idle_suspend;
      RX_SUSPENDED && !RX_POLL_DEMAND && !DESC_LIST_LOAD && !SOFT_RESET_REQ && !SOFT_RESET_BUSY;
   endsequence
   chk_irq_one_pulse: assert property (RX_IRQ |=> !RX_IRQ)
      else $error("receive interrupt longer than one cycle");
   chk_reset_starts: assert property (SOFT_RESET_REQ |=> SOFT_RESET_BUSY)
      else $error("soft reset did not start");
   chk_busy_refuses: assert property (SOFT_RESET_BUSY |-> !RX_READY)
      else $error("line bytes taken during soft reset");
   chk_phy_stall: assert property (SOFT_RESET_BUSY && !PHY_CLK_ALIVE && !SOFT_RESET_REQ |=> SOFT_RESET_BUSY)
      else $error("soft reset ended without phy clock");
   chk_phy_done: assert property (SOFT_RESET_BUSY && PHY_CLK_ALIVE && !SOFT_RESET_REQ |=> !SOFT_RESET_BUSY)
      else $error("soft reset did not end with phy clock");
   chk_base_load: assert property (DESC_LIST_LOAD && !SOFT_RESET_BUSY && !SOFT_RESET_REQ
      |=> DESC_LIST_BASE_RD == $past(DESC_LIST_BASE))
      else $error("list base read back differs");
   chk_suspend_hold: assert property (s_idle_suspend |=> RX_SUSPENDED)
      else $error("engine left suspend without poll");
   chk_poll_refetch: assert property (RX_SUSPENDED && RX_POLL_DEMAND && !SOFT_RESET_BUSY |-> s_refetch)
      else $error("poll demand did not refetch descriptor");
   chk_wake_irq_same: assert property ((WAKE_STATUS == POWER_MGMT_IRQ)
      && (!$rose(POWER_MGMT_IRQ) || $past(POWER_DOWN_ACTIVE)))
      else $error("power interrupt wrong or raised outside power-down");
   chk_wake_clear: assert property ($fell(WAKE_STATUS)
      |-> $past(WAKE_STATUS_READ) || $past(SOFT_RESET_REQ) || $past(SOFT_RESET_BUSY))
      else $error("wake status cleared without read");
endmodule

/* tb/ermw_host_mem.sv */
/*
 * Host memory model on the DMA port: 1 KiB of words, grants at full or half rate.
 * Assumes requests hold until granted and one outstanding read.
 */
module ermw_host_mem (
   input wire logic clk,
   input wire logic slow,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic mem_byte,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic mem_gnt,
   output logic mem_rvalid,
   output logic [31:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [0:255];
   logic tog = 1'b0;
   logic rv_q = 1'b0;
   logic [31:0] rd_q = 32'h0;
   assign mem_gnt = mem_req && (!slow || tog);
   assign mem_rvalid = rv_q;
   assign mem_rdata = rd_q;
   // Read data is inverted every idle cycle so stale data never looks valid.
   always @(posedge clk)
   begin
      tog <= !tog;
      rv_q <= mem_gnt && !mem_we;
      if (mem_gnt && !mem_we)
         rd_q <= mem[mem_addr[9:2]];
      else
         rd_q <= ~rd_q;
      if (mem_gnt && mem_we && mem_byte)
         mem[mem_addr[9:2]][8*mem_addr[1:0] +: 8] <= mem_wdata[7:0];
      else if (mem_gnt && mem_we)
         mem[mem_addr[9:2]] <= mem_wdata;
   end
endmodule

/* tb/ermw_rx_mac_bench.sv */
/*
 * Self-checking bench of the receive MAC: DMA lists, FIFO fill, watchdog, wake filters, soft reset.
 * Assumes ermw_pkg, ermw_defs.svh, the host memory model and the checker.
 */
`include "ermw_defs.svh"
module ermw_rx_mac_bench import ermw_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;
   logic CLOCK = 1'b0, RST_N = 1'b0, RX_VALID = 1'b0, RX_LAST = 1'b0, RX_MCAST = 1'b0, RX_ENABLE = 1'b0;
   logic [7:0] RX_DATA = 8'h0, RX_WATCHDOG_TIMEOUT = 8'h0;
   logic POWER_DOWN_REQ = 1'b0, WAKE_STATUS_READ = 1'b0, SOFT_RESET_REQ = 1'b0, PHY_CLK_ALIVE = 1'b1;
   logic DESC_LIST_LOAD = 1'b0, RX_POLL_DEMAND = 1'b0, slow = 1'b0;
   logic [31:0] DESC_LIST_BASE = 32'h0;
   logic [4:0] DESC_SKIP_WORDS = 5'h0;
   ermw_wake_cfg_type [`ERMW_WAKE_FILTERS-1:0] WAKE_CFG = '0;
   logic RX_READY, POWER_DOWN_ACTIVE, WAKE_STATUS, POWER_MGMT_IRQ, SOFT_RESET_BUSY, RX_SUSPENDED, RX_IRQ;
   logic MEM_REQ, MEM_WE, MEM_BYTE, MEM_GNT, MEM_RVALID;
   logic [31:0] DESC_LIST_BASE_RD, CUR_BUF_ADDR, CUR_DESC_ADDR, MEM_ADDR, MEM_WDATA, MEM_RDATA;
   int bad_count = 0;
   int n_tests = 0;
   int acc = 0;
   int cyc = 0;
   int n;
   ermw_rx_mac #(.FIFO_DEPTH(`ERMW_FIFO_DEPTH)) i_dut (.*);
   ermw_host_mem i_mem (.clk(CLOCK), .slow(slow), .mem_req(MEM_REQ), .mem_we(MEM_WE), .mem_byte(MEM_BYTE),
      .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA), .mem_gnt(MEM_GNT), .mem_rvalid(MEM_RVALID),
      .mem_rdata(MEM_RDATA));
   always #2 CLOCK = ~CLOCK;
   always @(posedge CLOCK)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         bad_count++;
         results();
      end
   end
   task results;
      if (bad_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task tick(input int k);
      repeat (k) @(posedge CLOCK);
   endtask
   task send(input int len, input logic [7:0] b0, input logic mc);
      logic rdy;
      @(posedge CLOCK);
      for (int i = 0; i < len; i++)
      begin
         RX_VALID <= 1'b1;
         RX_DATA <= b0 + 8'(i);
         RX_LAST <= (i == len - 1);
         RX_MCAST <= mc;
         do
         begin
            @(negedge CLOCK);
            rdy = RX_READY;
            @(posedge CLOCK);
         end
         while (rdy !== 1'b1);
         acc++;
      end
      RX_VALID <= 1'b0;
      RX_LAST <= 1'b0;
   endtask
   task wait_irq;
      n = 0;
      do
      begin
         @(negedge CLOCK);
         n++;
      end
      while (RX_IRQ !== 1'b1 && n < 1000);
   endtask
   task wait_suspend;
      do @(negedge CLOCK);
      while (RX_SUSPENDED !== 1'b1);
   endtask
   function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
         r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? 16'h8005 : 16'h0);
      return r;
   endfunction
   task t_unchained;
      i_mem.mem[8'h40] = 32'h80000000;
      i_mem.mem[8'h41] = 32'h00040004;
      i_mem.mem[8'h42] = 32'h00000200;
      i_mem.mem[8'h43] = 32'h00000280;
      for (int i = 8'h46; i < 8'h4a; i++)
         i_mem.mem[i] = 32'h0;
      i_mem.mem[8'h48] = 32'h300;
      @(posedge CLOCK);
      DESC_SKIP_WORDS <= 5'h2;
      DESC_LIST_BASE <= 32'h100;
      DESC_LIST_LOAD <= 1'b1;
      @(posedge CLOCK);
      DESC_LIST_LOAD <= 1'b0;
      RX_ENABLE <= 1'b1;
      send(6, 8'ha0, 1'b0);
      wait_irq();
      chk("irq after frame", 1, n < 1000);
      wait_suspend();
      chk("first buffer", 32'ha3a2a1a0, i_mem.mem[8'h80]);
      chk("second buffer", 32'ha5a4, {16'h0, i_mem.mem[8'ha0][15:0]});
      chk("status word", 32'h00060000, i_mem.mem[8'h40]);
      chk("next descriptor", 32'h118, CUR_DESC_ADDR);
      chk("buffer address", 32'h300, CUR_BUF_ADDR);
      chk("list base", 32'h100, DESC_LIST_BASE_RD);
   endtask
   task t_fill_poll;
      chk("suspended", 1, RX_SUSPENDED);
      @(posedge CLOCK);
      slow <= 1'b1;
      RX_WATCHDOG_TIMEOUT <= 8'h2;
      acc = 0;
      fork
         send(20, 8'hb0, 1'b0);
         begin
            tick(40);
            chk("fifo fill", `ERMW_FIFO_DEPTH, acc);
            i_mem.mem[8'h47] = 32'h80004040;
            i_mem.mem[8'h48] = 32'h00000300;
            i_mem.mem[8'h49] = 32'h00000140;
            i_mem.mem[8'h46] = 32'h80000000;
            for (int i = 8'h50; i < 8'h54; i++)
               i_mem.mem[i] = 32'h0;
            RX_POLL_DEMAND <= 1'b1;
            @(posedge CLOCK);
            RX_POLL_DEMAND <= 1'b0;
         end
      join
      wait_irq();
      chk("watchdog delay", 1, n >= 500 && n < 700);
      wait_suspend();
      chk("chained next", 32'h140, CUR_DESC_ADDR);
      chk("chained buffer", 32'hb3b2b1b0, i_mem.mem[8'hc0]);
      @(posedge CLOCK);
      slow <= 1'b0;
   endtask
   task t_wd_off;
      i_mem.mem[8'h50] = 32'h80000000;
      i_mem.mem[8'h51] = 32'h80000004;
      i_mem.mem[8'h52] = 32'h00000380;
      for (int i = 8'h56; i < 8'h5a; i++)
         i_mem.mem[i] = 32'h0;
      @(posedge CLOCK);
      RX_WATCHDOG_TIMEOUT <= 8'h0;
      RX_POLL_DEMAND <= 1'b1;
      @(posedge CLOCK);
      RX_POLL_DEMAND <= 1'b0;
      send(2, 8'hc0, 1'b0);
      wait_irq();
      chk("watchdog off", 0, n < 1000);
      chk("zero timeout data", 32'hc1c0, {16'h0, i_mem.mem[8'he0][15:0]});
   endtask
   task t_wake;
      logic [15:0] crc;
      crc = crc_upd(crc_upd(16'hffff, 8'h12), 8'h14);
      @(posedge CLOCK);
      POWER_DOWN_REQ <= 1'b1;
      for (int k = 0; k < 3; k++)
      begin
         @(posedge CLOCK);
         WAKE_CFG[0] <= '{31'h5, 8'h08, 8'h02, crc};
         WAKE_CFG[1] <= '{31'h5, 8'h09, 8'h02, crc};
         WAKE_CFG[2] <= '{31'h5, 8'h00, 8'h02, crc};
         WAKE_CFG[3] <= '{31'h5, (k == 0) ? 8'h00 : 8'h01, 8'h02, crc ^ 16'(k == 1)};
         send(8, 8'h10, 1'b0);
         tick(4);
         @(negedge CLOCK);
         chk("wake status", k == 2, WAKE_STATUS);
      end
      chk("power irq", 1, POWER_MGMT_IRQ);
      chk("power down left", 0, POWER_DOWN_ACTIVE);
      @(posedge CLOCK);
      WAKE_STATUS_READ <= 1'b1;
      @(posedge CLOCK);
      WAKE_STATUS_READ <= 1'b0;
      POWER_DOWN_REQ <= 1'b0;
      tick(2);
      @(negedge CLOCK);
      chk("wake cleared", 0, WAKE_STATUS);
   endtask
   task t_soft_reset;
      @(posedge CLOCK);
      PHY_CLK_ALIVE <= 1'b0;
      SOFT_RESET_REQ <= 1'b1;
      @(posedge CLOCK);
      SOFT_RESET_REQ <= 1'b0;
      tick(30);
      @(negedge CLOCK);
      chk("reset waits", 1, SOFT_RESET_BUSY);
      @(posedge CLOCK);
      PHY_CLK_ALIVE <= 1'b1;
      tick(3);
      @(negedge CLOCK);
      chk("reset done", 0, SOFT_RESET_BUSY);
      chk("base cleared", 0, DESC_LIST_BASE_RD);
      chk("descriptor cleared", 0, CUR_DESC_ADDR);
   endtask
   initial
   begin
      tick(10);
      RST_N <= 1'b1;
      tick(2);
      t_unchained();
      t_fill_poll();
      t_wd_off();
      t_wake();
      t_soft_reset();
      results();
   end
endmodule
bind ermw_rx_mac ermw_rx_chk i_chk (.CLOCK(CLOCK), .RST_N(RST_N), .RX_READY(RX_READY),
   .SOFT_RESET_REQ(SOFT_RESET_REQ), .PHY_CLK_ALIVE(PHY_CLK_ALIVE), .SOFT_RESET_BUSY(SOFT_RESET_BUSY),
   .DESC_LIST_BASE(DESC_LIST_BASE), .DESC_LIST_LOAD(DESC_LIST_LOAD), .DESC_LIST_BASE_RD(DESC_LIST_BASE_RD),
   .RX_POLL_DEMAND(RX_POLL_DEMAND), .CUR_DESC_ADDR(CUR_DESC_ADDR), .RX_SUSPENDED(RX_SUSPENDED),
   .RX_IRQ(RX_IRQ), .WAKE_STATUS_READ(WAKE_STATUS_READ), .WAKE_STATUS(WAKE_STATUS),
   .POWER_DOWN_ACTIVE(POWER_DOWN_ACTIVE),
   .POWER_MGMT_IRQ(POWER_MGMT_IRQ), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR));
